// ===== hw/pdmc_pkg.sv
/*
 * Shared definitions for the power-down mode controller: register map,
 * field positions, reset values, mode encoding and the halt bundle.
 * Assumes a 20-bit register address and 8-bit register data.
 */
package pdmc_pkg;

	// Register map, low 20 address bits
	localparam logic [19:0] PWR_CTRL_ADDR = 20'hEE012;
	localparam logic [19:0] HALT_HIGH_ADDR = 20'hEE01C;
	localparam logic [19:0] HALT_LOW_ADDR = 20'hEE01D;

	// Reset values
	localparam logic [7:0] PWR_CTRL_RESET = 8'h09;
	localparam logic [7:0] HALT_HIGH_RESET = 8'h78;
	localparam logic [7:0] HALT_LOW_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Bits of the high halt register that always read as one
	localparam logic [7:0] HALT_HIGH_FIXED = 8'h78;

	// Power control fields
	localparam int DEEP_STANDBY_BIT = 7;
	localparam int SETTLE_SEL_MSB = 6;
	localparam int SETTLE_SEL_LSB = 4;
	localparam int BUS_HOLD_BIT = 1;
	localparam int RAM_ENABLE_BIT = 0;

	// High halt fields
	localparam int CLKOUT_OFF_BIT = 7;
	localparam int SERIAL1_BIT = 1;
	localparam int SERIAL0_BIT = 0;

	// Low halt fields
	localparam int TIMER16_BIT = 4;
	localparam int TIMER8A_BIT = 3;
	localparam int TIMER8B_BIT = 2;
	localparam int ADC_BIT = 0;

	// Settle wait select codes
	localparam logic [2:0] SETTLE_CODE_SHORT = 3'h6;
	localparam logic [2:0] SETTLE_CODE_ILLEGAL = 3'h7;

	// Width of the settle wait counter
	localparam int SETTLE_WIDTH = 19;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b000,
		MODE_SLEEP = 3'b001,
		MODE_SOFT_STANDBY = 3'b010,
		MODE_SETTLE = 3'b011,
		MODE_HW_STANDBY = 3'b100
	} pdmc_mode_e;

	// One bit per peripheral: high means halted and held in reset
	typedef struct packed {
		logic timer16;
		logic timer8PairA;
		logic timer8PairB;
		logic serial0;
		logic serial1;
		logic adc;
	} pdmc_periph_s;

endpackage

// ===== hw/pdmc_settle_counter.sv
/*
 * Settle wait counter: counts system clock states after a start pulse
 * and gives a one-cycle done pulse. Assumes load is at least two and
 * that abort clears it on hardware standby or a clear.
 */
`timescale 1ns/100ps
module pdmc_settle_counter #(
	parameter int WIDTH = pdmc_pkg::SETTLE_WIDTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [WIDTH-1:0] load,
	// Status
	output logic busy,
	output logic done
);

	logic [WIDTH-1:0] remaining;

	// Counts states of the system clock, so the wait scales with the divider
	always_ff @(posedge clock) begin
		if (!rst_b || abort) begin
			remaining <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			// Two less: done is registered and the mode follows it a cycle later
			remaining <= load - WIDTH'(2);
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			if (remaining == '0) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				remaining <= remaining - WIDTH'(1);
				done <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end

endmodule

// ===== hw/pdmc_power_down.sv
/*
 * Power-down mode controller: sleep, software standby, hardware standby
 * and per-peripheral halt, with its three 8-bit control registers.
 * Assumes halt and wake requests come from logic on the same clock, the
 * two pins are asynchronous, and the clock keeps running for this block.
 */
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module pdmc_power_down #(
	parameter int WAIT_CODE0 = 8192,
	parameter int WAIT_CODE1 = 16384,
	parameter int WAIT_CODE2 = 32768,
	parameter int WAIT_CODE3 = 65536,
	parameter int WAIT_CODE4 = 131072,
	parameter int WAIT_CODE5 = 262144,
	parameter int WAIT_CODE6 = 1024
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Register port
	input wire logic [19:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// CPU and interrupt side
	input wire logic haltInstr,
	input wire logic sleepWake,
	input wire logic standbyWake,
	output logic cpuHalt,
	output logic clockRun,
	output logic oscRun,
	output logic irqStart,
	output pdmc_pkg::pdmc_mode_e mode,
	// Pins
	input wire logic hwStandbyPin_b,
	input wire logic powerOnClearPin_b,
	// Peripheral control
	output pdmc_pkg::pdmc_periph_s periphHalt,
	output logic otherPeriphReset,
	output logic onchipRamEnable,
	// Clock output pin
	output logic clkOutGate,
	output logic clkOutValue,
	output logic clkOutOe,
	// External bus and ports
	output logic busOe,
	output logic busStrobeHigh,
	output logic busAddrFreeze,
	output logic portsFloat
);

	localparam int W = pdmc_pkg::SETTLE_WIDTH;

	if (WAIT_CODE0 < 2 || WAIT_CODE1 < 2 || WAIT_CODE2 < 2 || WAIT_CODE3 < 2 ||
		WAIT_CODE4 < 2 || WAIT_CODE5 < 2 || WAIT_CODE6 < 2) begin : g_waitTooShort
		$error("settle wait counts must be at least two states");
	end
	if (WAIT_CODE5 >= (1 << W) || WAIT_CODE4 >= (1 << W)) begin : g_waitTooLong
		$error("settle wait count does not fit the counter");
	end

	// Pin synchronisers: bit 1 hardware standby, bit 0 power-on clear
	logic [1:0] pinMeta;
	logic [1:0] pinSync;
	logic [1:0] pinRaw;
	assign pinRaw = {hwStandbyPin_b, powerOnClearPin_b};

	for (genvar i = 0; i < 2; i++) begin : g_pinSync
		always_ff @(posedge clock) begin
			if (!rst_b) begin
				pinMeta[i] <= 1'b1;
				pinSync[i] <= 1'b1;
			end else begin
				pinMeta[i] <= pinRaw[i];
				pinSync[i] <= pinMeta[i];
			end
		end
	end

	logic hwStandby;
	logic pinClear;
	logic regClear;
	assign hwStandby = !pinSync[1];
	assign pinClear = !pinSync[0];
	assign regClear = !rst_b || hwStandby || pinClear;

	// Registers
	logic [7:0] powerControl;
	logic [7:0] haltHigh;
	logic [7:0] haltLow;

	logic deepStandby;
	logic [2:0] settleSel;
	logic busHold;
	assign deepStandby = powerControl[pdmc_pkg::DEEP_STANDBY_BIT];
	assign settleSel = powerControl[pdmc_pkg::SETTLE_SEL_MSB:pdmc_pkg::SETTLE_SEL_LSB];
	assign busHold = powerControl[pdmc_pkg::BUS_HOLD_BIT];

	function automatic logic [7:0] readMux(input logic [19:0] addr, input logic [7:0] pc,
		input logic [7:0] hh, input logic [7:0] hl);
		unique case (addr)
			pdmc_pkg::PWR_CTRL_ADDR: readMux = pc;
			pdmc_pkg::HALT_HIGH_ADDR: readMux = hh | pdmc_pkg::HALT_HIGH_FIXED;
			pdmc_pkg::HALT_LOW_ADDR: readMux = hl;
			default: readMux = pdmc_pkg::READ_IDLE;
		endcase
	endfunction

	// Deep standby clears with the register on reset, hardware standby or a clear; otherwise only a write changes it
	always_ff @(posedge clock) begin
		if (regClear) begin
			powerControl <= pdmc_pkg::PWR_CTRL_RESET;
		end else if (regWrite && regAddr == pdmc_pkg::PWR_CTRL_ADDR) begin
			powerControl <= regWrData;
		end
	end

	always_ff @(posedge clock) begin
		if (regClear) begin
			haltHigh <= pdmc_pkg::HALT_HIGH_RESET;
		end else if (regWrite && regAddr == pdmc_pkg::HALT_HIGH_ADDR) begin
			haltHigh <= regWrData | pdmc_pkg::HALT_HIGH_FIXED;
		end
	end

	always_ff @(posedge clock) begin
		if (regClear) begin
			haltLow <= pdmc_pkg::HALT_LOW_RESET;
		end else if (regWrite && regAddr == pdmc_pkg::HALT_LOW_ADDR) begin
			haltLow <= regWrData;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			regRdData <= pdmc_pkg::READ_IDLE;
		end else if (regRead) begin
			regRdData <= readMux(regAddr, powerControl, haltHigh, haltLow);
		end else begin
			regRdData <= pdmc_pkg::READ_IDLE;
		end
	end

	// Settle wait length; the illegal code falls back to the wait of code 5
	function automatic logic [W-1:0] waitStates(input logic [2:0] code);
		unique case (code)
			3'h0: waitStates = W'(WAIT_CODE0);
			3'h1: waitStates = W'(WAIT_CODE1);
			3'h2: waitStates = W'(WAIT_CODE2);
			3'h3: waitStates = W'(WAIT_CODE3);
			3'h4: waitStates = W'(WAIT_CODE4);
			3'h5: waitStates = W'(WAIT_CODE5);
			pdmc_pkg::SETTLE_CODE_SHORT: waitStates = W'(WAIT_CODE6);
			pdmc_pkg::SETTLE_CODE_ILLEGAL: waitStates = W'(WAIT_CODE5);
		endcase
	endfunction

	// Mode sequencing
	pdmc_pkg::pdmc_mode_e next_mode;
	logic settleStart;
	logic settleDone;
	logic settleBusy;
	logic next_irqStart;

	always_comb begin
		next_mode = mode;
		settleStart = 1'b0;
		next_irqStart = 1'b0;
		if (hwStandby) begin
			next_mode = pdmc_pkg::MODE_HW_STANDBY;
		end else if (pinClear) begin
			next_mode = pdmc_pkg::MODE_RUN;
		end else begin
			unique case (mode)
				pdmc_pkg::MODE_RUN: begin
					if (haltInstr && deepStandby) begin
						next_mode = pdmc_pkg::MODE_SOFT_STANDBY;
					end else if (haltInstr) begin
						next_mode = pdmc_pkg::MODE_SLEEP;
					end
				end
				pdmc_pkg::MODE_SLEEP: begin
					if (sleepWake) begin
						next_mode = pdmc_pkg::MODE_RUN;
						next_irqStart = 1'b1;
					end
				end
				pdmc_pkg::MODE_SOFT_STANDBY: begin
					if (standbyWake) begin
						next_mode = pdmc_pkg::MODE_SETTLE;
						settleStart = 1'b1;
					end
				end
				pdmc_pkg::MODE_SETTLE: begin
					if (settleDone) begin
						next_mode = pdmc_pkg::MODE_RUN;
						next_irqStart = 1'b1;
					end
				end
				pdmc_pkg::MODE_HW_STANDBY: begin
					next_mode = pdmc_pkg::MODE_RUN;
				end
				default: begin
					next_mode = pdmc_pkg::MODE_RUN;
				end
			endcase
		end
	end

	pdmc_settle_counter #(
		.WIDTH(W)
	) u_settle (
		.clock(clock),
		.rst_b(rst_b),
		.start(settleStart),
		.abort(hwStandby || pinClear),
		.load(waitStates(settleSel)),
		.busy(settleBusy),
		.done(settleDone)
	);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mode <= pdmc_pkg::MODE_RUN;
			irqStart <= 1'b0;
		end else begin
			mode <= next_mode;
			irqStart <= next_irqStart;
		end
	end

	// Outputs follow the mode being entered so they line up with it
	logic next_deep;
	logic next_soft;
	logic next_hw;
	assign next_hw = next_mode == pdmc_pkg::MODE_HW_STANDBY;
	assign next_soft = next_mode == pdmc_pkg::MODE_SOFT_STANDBY || next_mode == pdmc_pkg::MODE_SETTLE;
	assign next_deep = next_soft || next_hw;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cpuHalt <= 1'b0;
			clockRun <= 1'b1;
			oscRun <= 1'b1;
			otherPeriphReset <= 1'b0;
		end else begin
			cpuHalt <= next_mode != pdmc_pkg::MODE_RUN;
			clockRun <= !next_deep;
			oscRun <= next_mode != pdmc_pkg::MODE_SOFT_STANDBY && !next_hw;
			otherPeriphReset <= next_deep;
		end
	end

	// Per-peripheral halt; sleep alone leaves peripherals running
	logic [5:0] haltBits;
	logic [5:0] haltOut;
	assign haltBits = {haltLow[pdmc_pkg::TIMER16_BIT], haltLow[pdmc_pkg::TIMER8A_BIT],
		haltLow[pdmc_pkg::TIMER8B_BIT], haltHigh[pdmc_pkg::SERIAL0_BIT],
		haltHigh[pdmc_pkg::SERIAL1_BIT], haltLow[pdmc_pkg::ADC_BIT]};

	for (genvar p = 0; p < 6; p++) begin : g_periph
		always_ff @(posedge clock) begin
			if (!rst_b) begin
				haltOut[p] <= 1'b0;
			end else begin
				haltOut[p] <= haltBits[p] || next_deep;
			end
		end
	end
	assign periphHalt = pdmc_pkg::pdmc_periph_s'(haltOut);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			onchipRamEnable <= 1'b1;
		end else begin
			onchipRamEnable <= powerControl[pdmc_pkg::RAM_ENABLE_BIT];
		end
	end

	// Clock output pin: high in software standby, floating in hardware standby
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			clkOutGate <= 1'b1;
			clkOutValue <= 1'b0;
			clkOutOe <= 1'b1;
		end else begin
			clkOutGate <= !next_deep && !haltHigh[pdmc_pkg::CLKOUT_OFF_BIT];
			clkOutValue <= next_soft;
			clkOutOe <= !next_hw && (next_soft || !haltHigh[pdmc_pkg::CLKOUT_OFF_BIT]);
		end
	end

	// External bus behaviour in the standby modes
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			busOe <= 1'b1;
			busStrobeHigh <= 1'b0;
			busAddrFreeze <= 1'b0;
			portsFloat <= 1'b0;
		end else begin
			busOe <= !next_hw && (!next_soft || busHold);
			busStrobeHigh <= next_soft && busHold;
			busAddrFreeze <= next_soft && busHold;
			portsFloat <= next_hw;
		end
	end

	// Helper for checking the settle length
	logic [W-1:0] settleLen;
	logic [W-1:0] settleTarget;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			settleLen <= '0;
			settleTarget <= '0;
		end else begin
			settleLen <= (mode == pdmc_pkg::MODE_SETTLE) ? settleLen + W'(1) : '0;
			if (settleStart) begin
				settleTarget <= waitStates(settleSel);
			end
		end
	end

	property p_sleepEntry;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_RUN && haltInstr && !deepStandby && !hwStandby && !pinClear)
		|=> (mode == pdmc_pkg::MODE_SLEEP && cpuHalt && clockRun);
	endproperty
	a_sleepEntry: assert property (p_sleepEntry) else $error("sleep not entered");

	property p_softEntry;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_RUN && haltInstr && deepStandby && !hwStandby && !pinClear)
		|=> (mode == pdmc_pkg::MODE_SOFT_STANDBY && !clockRun && clkOutOe && clkOutValue && periphHalt == '1);
	endproperty
	a_softEntry: assert property (p_softEntry) else $error("software standby not entered");

	property p_deepKept;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_SETTLE ##1 mode == pdmc_pkg::MODE_RUN) |-> deepStandby;
	endproperty
	a_deepKept: assert property (p_deepKept) else $error("deep standby bit lost on wake");

	property p_settleLength;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_SETTLE && settleDone && !hwStandby && !pinClear)
		|-> (settleLen == settleTarget - W'(1));
	endproperty
	a_settleLength: assert property (p_settleLength) else $error("settle wait length wrong");

	property p_busFloat;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_SOFT_STANDBY && $stable(busHold) && !busHold) |-> !busOe;
	endproperty
	a_busFloat: assert property (p_busFloat) else $error("bus not floated");

	property p_busHold;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_SOFT_STANDBY && $stable(busHold) && busHold)
		|-> (busOe && busStrobeHigh && busAddrFreeze);
	endproperty
	a_busHold: assert property (p_busHold) else $error("bus not held");

	property p_moduleHalt;
		@(posedge clock) disable iff (!rst_b)
		(regWrite && regAddr == pdmc_pkg::HALT_LOW_ADDR && regWrData[pdmc_pkg::TIMER16_BIT] && !regClear)
		|=> ##1 periphHalt.timer16;
	endproperty
	a_moduleHalt: assert property (p_moduleHalt) else $error("timer halt not applied");

	property p_resetValues;
		@(posedge clock)
		!rst_b |=> (powerControl == pdmc_pkg::PWR_CTRL_RESET && haltHigh == pdmc_pkg::HALT_HIGH_RESET
			&& haltLow == pdmc_pkg::HALT_LOW_RESET);
	endproperty
	a_resetValues: assert property (p_resetValues) else $error("register reset value wrong");

	property p_highReadOnes;
		@(posedge clock) disable iff (!rst_b)
		(regRead && regAddr == pdmc_pkg::HALT_HIGH_ADDR) |=> (regRdData[6:3] == 4'hF);
	endproperty
	a_highReadOnes: assert property (p_highReadOnes) else $error("fixed bits not one");

	property p_sleepExit;
		@(posedge clock) disable iff (!rst_b)
		(mode == pdmc_pkg::MODE_SLEEP && sleepWake && !hwStandby && !pinClear)
		|=> (mode == pdmc_pkg::MODE_RUN && irqStart) ##1 !irqStart;
	endproperty
	a_sleepExit: assert property (p_sleepExit) else $error("sleep exit wrong");

	property p_hwStandby;
		@(posedge clock) disable iff (!rst_b)
		hwStandby |=> (mode == pdmc_pkg::MODE_HW_STANDBY && !clkOutOe && portsFloat && !busOe);
	endproperty
	a_hwStandby: assert property (p_hwStandby) else $error("hardware standby not forced");

	c_sleepCycle: cover property (@(posedge clock) disable iff (!rst_b)
		mode == pdmc_pkg::MODE_SLEEP ##1 mode == pdmc_pkg::MODE_RUN);
	c_settleDone: cover property (@(posedge clock) disable iff (!rst_b)
		mode == pdmc_pkg::MODE_SETTLE ##1 mode == pdmc_pkg::MODE_RUN);
	c_hwStandby: cover property (@(posedge clock) disable iff (!rst_b)
		mode == pdmc_pkg::MODE_HW_STANDBY);

endmodule

// ===== verification/tb_top.sv
/*
 * Self-checking bench for the power-down mode controller: register map,
 * peripheral halt bits, sleep, every settle code of software standby,
 * and hardware standby through its pin.
 * Assumes the package and design files under hw/ are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
	logic clock;
	logic rst_b;
	logic [19:0] regAddr;
	logic [7:0] regWrData;
	logic regWrite;
	logic regRead;
	logic [7:0] regRdData;
	logic haltInstr;
	logic sleepWake;
	logic standbyWake;
	logic cpuHalt;
	logic clockRun;
	logic oscRun;
	logic irqStart;
	pdmc_pkg::pdmc_mode_e mode;
	logic hwStandbyPin_b;
	logic powerOnClearPin_b;
	pdmc_pkg::pdmc_periph_s periphHalt;
	logic otherPeriphReset;
	logic onchipRamEnable;
	logic clkOutGate;
	logic clkOutValue;
	logic clkOutOe;
	logic busOe;
	logic busStrobeHigh;
	logic busAddrFreeze;
	logic portsFloat;
	int fails;
	int testsRun;
	int n;
	time t0;
	// Codes 1 to 5 shortened so every code can be run; 0 and 6 keep full counts
	int waitTab[8] = '{8192, 16, 32, 64, 128, 256, 1024, 256};
	logic [7:0] lowTab[6] = '{8'h10, 8'h08, 8'h04, 8'h00, 8'h00, 8'h01};
	logic [7:0] highTab[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
	logic [7:0] expTab[6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

	pdmc_power_down #(.WAIT_CODE1(16), .WAIT_CODE2(32), .WAIT_CODE3(64),
		.WAIT_CODE4(128), .WAIT_CODE5(256)) dut (
		.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .haltInstr(haltInstr),
		.sleepWake(sleepWake), .standbyWake(standbyWake), .cpuHalt(cpuHalt), .clockRun(clockRun),
		.oscRun(oscRun), .irqStart(irqStart), .mode(mode), .hwStandbyPin_b(hwStandbyPin_b),
		.powerOnClearPin_b(powerOnClearPin_b), .periphHalt(periphHalt),
		.otherPeriphReset(otherPeriphReset), .onchipRamEnable(onchipRamEnable),
		.clkOutGate(clkOutGate), .clkOutValue(clkOutValue), .clkOutOe(clkOutOe), .busOe(busOe),
		.busStrobeHigh(busStrobeHigh), .busAddrFreeze(busAddrFreeze), .portsFloat(portsFloat));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic complete_run();
		if (fails == 0 && testsRun > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk({8'h00, regRdData}, {8'h00, exp});
	endtask

	task automatic halt_cpu();
		@(posedge clock);
		haltInstr <= 1'b1;
		@(posedge clock);
		haltInstr <= 1'b0;
		#1;
	endtask

	task automatic wait_mode(input pdmc_pkg::pdmc_mode_e m, input int lim, output int cnt);
		cnt = 0;
		while (mode !== m && cnt < lim) begin
			@(posedge clock);
			#1;
			cnt++;
		end
		if (mode !== m) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, mode, m);
			complete_run();
		end
	endtask

	task automatic standby_cycle(input logic [7:0] ctrl, input int waitLen);
		int cnt;
		wr(pdmc_pkg::PWR_CTRL_ADDR, ctrl);
		halt_cpu();
		chk({13'h0, mode}, {13'h0, pdmc_pkg::MODE_SOFT_STANDBY});
		chk({clockRun, oscRun, cpuHalt, otherPeriphReset}, 4'b0011);
		chk({clkOutOe, clkOutGate, clkOutValue}, 3'b101);
		chk({10'h0, periphHalt}, 16'h003F);
		chk({busOe, busStrobeHigh, busAddrFreeze}, {3{ctrl[1]}});
		@(posedge clock);
		standbyWake <= 1'b1;
		@(posedge clock);
		standbyWake <= 1'b0;
		#1;
		chk({13'h0, mode}, {13'h0, pdmc_pkg::MODE_SETTLE});
		chk({oscRun, clockRun}, 2'b10);
		wait_mode(pdmc_pkg::MODE_RUN, 10000, cnt);
		chk(cnt[15:0], waitLen[15:0]);
		chk({irqStart, clockRun, cpuHalt}, 3'b110);
		chk({10'h0, periphHalt}, 16'h0000);
	endtask

	initial begin
		rst_b = 1'b0;
		regAddr = 20'h00000;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		haltInstr = 1'b0;
		sleepWake = 1'b0;
		standbyWake = 1'b0;
		hwStandbyPin_b = 1'b1;
		powerOnClearPin_b = 1'b1;
		fails = 0;
		testsRun = 0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		rd(pdmc_pkg::PWR_CTRL_ADDR, 8'h09);
		rd(pdmc_pkg::HALT_HIGH_ADDR, 8'h78);
		rd(pdmc_pkg::HALT_LOW_ADDR, 8'h00);
		rd(20'hEE013, 8'h00);
		wr(pdmc_pkg::HALT_HIGH_ADDR, 8'h00);
		rd(pdmc_pkg::HALT_HIGH_ADDR, 8'h78);
		// One peripheral at a time, so a swapped bit shows
		for (int i = 0; i < 6; i++) begin
			wr(pdmc_pkg::HALT_LOW_ADDR, lowTab[i]);
			wr(pdmc_pkg::HALT_HIGH_ADDR, highTab[i]);
			@(posedge clock);
			#1;
			chk({10'h0, periphHalt}, {8'h00, expTab[i]});
		end
		wr(pdmc_pkg::HALT_HIGH_ADDR, 8'h80);
		@(posedge clock);
		#1;
		chk({15'h0, clkOutOe}, 16'h0000);
		rd(pdmc_pkg::HALT_HIGH_ADDR, 8'hF8);
		wr(pdmc_pkg::HALT_HIGH_ADDR, 8'h03);
		wr(pdmc_pkg::HALT_LOW_ADDR, 8'h1D);
		rd(pdmc_pkg::HALT_LOW_ADDR, 8'h1D);
		halt_cpu();
		chk({13'h0, mode}, {13'h0, pdmc_pkg::MODE_SLEEP});
		chk({cpuHalt, clockRun, oscRun}, 3'b111);
		chk({10'h0, periphHalt}, 16'h003F);
		@(posedge clock);
		sleepWake <= 1'b1;
		@(posedge clock);
		sleepWake <= 1'b0;
		#1;
		chk({13'h0, mode}, {13'h0, pdmc_pkg::MODE_RUN});
		chk({15'h0, irqStart}, 16'h0001);
		wr(pdmc_pkg::HALT_LOW_ADDR, 8'h00);
		wr(pdmc_pkg::HALT_HIGH_ADDR, 8'h00);
		// Every settle code, bus hold alternating; code 7 falls back to the wait of code 5
		// The longest codes stand for the crystal case, shortened to keep the run brief
		for (int c = 0; c < 8; c++) begin
			t0 = $time;
			standby_cycle({1'b1, c[2:0], 2'b10, c[0], 1'b1}, waitTab[c]);
			if (c == 0) begin
				// Full-length code 0 at a 50 ns clock must clear the 100 us floor
				chk({15'h0, ($time - t0) >= 100000}, 16'h0001);
			end
			rd(pdmc_pkg::PWR_CTRL_ADDR, {1'b1, c[2:0], 2'b10, c[0], 1'b1});
		end
		wr(pdmc_pkg::PWR_CTRL_ADDR, 8'h0A);
		rd(pdmc_pkg::PWR_CTRL_ADDR, 8'h0A);
		chk({15'h0, onchipRamEnable}, 16'h0000);
		wr(pdmc_pkg::HALT_LOW_ADDR, 8'h1D);
		@(posedge clock);
		hwStandbyPin_b <= 1'b0;
		wait_mode(pdmc_pkg::MODE_HW_STANDBY, 10, n);
		chk({portsFloat, busOe, clkOutOe, otherPeriphReset}, 4'b1001);
		chk({clockRun, oscRun, cpuHalt}, 3'b001);
		@(posedge clock);
		hwStandbyPin_b <= 1'b1;
		wait_mode(pdmc_pkg::MODE_RUN, 10, n);
		rd(pdmc_pkg::HALT_LOW_ADDR, 8'h00);
		rd(pdmc_pkg::PWR_CTRL_ADDR, 8'h09);
		chk({15'h0, onchipRamEnable}, 16'h0001);
		// Power-on clear pin out of sleep: back to run, registers cleared
		wr(pdmc_pkg::HALT_LOW_ADDR, 8'h11);
		halt_cpu();
		chk({13'h0, mode}, {13'h0, pdmc_pkg::MODE_SLEEP});
		chk({10'h0, periphHalt}, 16'h0021);
		@(posedge clock);
		powerOnClearPin_b <= 1'b0;
		wait_mode(pdmc_pkg::MODE_RUN, 10, n);
		chk({cpuHalt, irqStart}, 2'b00);
		@(posedge clock);
		powerOnClearPin_b <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk({10'h0, periphHalt}, 16'h0000);
		rd(pdmc_pkg::HALT_LOW_ADDR, 8'h00);
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		complete_run();
	end
endmodule
